// >>> hdl/outsel_pkg.sv
// package with modes, addresses and timing counts for the output source selector
package outsel_pkg;
  // ---------------------------------------------------------------
  // redundancy setting
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_DUPLEX = 2'h1,
    MODE_STANDBY = 2'h2,
    MODE_VOTED = 2'h3
  } red_mode_t;
  // ---------------------------------------------------------------
  // controller bus addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL_A = 5'h1F;
  localparam logic [4:0] ADDR_CTRL_B = 5'h1E;
  localparam logic [4:0] ADDR_CTRL_C = 5'h1D;
  // ---------------------------------------------------------------
  // loss detection in bus scans
  // ---------------------------------------------------------------
  localparam int LOSS_SCANS = 3;
  localparam int NUM_POINTS = 16;
  // ---------------------------------------------------------------
  // source selection states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_A = 4'h1,
    SRC_B = 4'h2,
    SRC_C = 4'h4,
    SRC_NONE = 4'h8
  } src_t;
endpackage

// >>> hdl/presence_tracker.sv
// per-controller presence tracker counting scans without data
module presence_tracker #(
  parameter int LOSS = 3
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // scan events
  input wire logic i_scan_end,
  input wire logic i_got_data,
  // status
  output logic o_present
);
  logic [3:0] miss_q;
  logic seen_q;

  // the miss counter is four bits wide, so longer loss intervals cannot be served
  if (LOSS < 1 || LOSS > 15)
  begin : g_bad_loss
    $error("LOSS out of range");
  end

  // data seen during the current scan
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      seen_q <= 1'b0;
    else if (i_scan_end)
      seen_q <= 1'b0;
    else if (i_got_data)
      seen_q <= 1'b1;
  end

  // data arriving in a scan keeps or restores presence at once
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      miss_q <= 4'(LOSS);
      o_present <= 1'b0;
    end
    else if (i_got_data)
    begin
      miss_q <= 4'h0;
      o_present <= 1'b1;
    end
    else if (i_scan_end && !seen_q)
    begin
      if (miss_q < 4'(LOSS))
        miss_q <= miss_q + 4'h1;
      if (miss_q + 4'h1 >= 4'(LOSS))
        o_present <= 1'b0;
    end
  end
endmodule // presence_tracker

// >>> hdl/output_selector.sv
// output source selector for a non-voted discrete output block
// ---------------------------------------------------------------
// Overview of operation
// - the block runs in one of four configured settings: voted, standby, duplex or none.
// - with no redundancy the outputs follow the single controller as in a simplex system.
// - in duplex the block takes commands from addresses 30 and 31 and compares each point.
// - in duplex a point both controllers agree on goes to the agreed state.
// - in duplex a point on which they differ goes to its duplex default.
// - in duplex if one controller goes silent the other one drives the points directly.
// - three-source standby uses address 31, else 30, else 29.
// - with no source in three-source standby points go to default or hold, as configured.
// - two-source standby follows 31 and moves to 30 after three scans without 31.
// - with neither 30 nor 31 in two-source standby points go to default or hold.
// - in standby address 31 takes control back whenever it is sending.
// - controllers are identified by address 31 as A, 30 as B and 29 as C.
// ---------------------------------------------------------------
module output_selector #(
  parameter int POINTS = outsel_pkg::NUM_POINTS,
  parameter int LOSS = outsel_pkg::LOSS_SCANS
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // configuration
  input wire logic [1:0] i_red_mode,
  input wire logic i_three_source,
  input wire logic i_hold_last,
  input wire logic [POINTS-1:0] i_default_state,
  input wire logic [POINTS-1:0] i_duplex_default,
  // bus side, one command frame per strobe
  input wire logic i_scan_end,
  input wire logic i_cmd_valid,
  input wire logic [4:0] i_cmd_addr,
  input wire logic [POINTS-1:0] i_cmd_data,
  input wire logic [POINTS-1:0] i_voted_data,
  // outputs and status
  output logic [POINTS-1:0] o_points,
  output logic [3:0] o_source,
  output logic [2:0] o_present
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (POINTS < 1 || POINTS > 32)
  begin : g_bad_points
    $error("POINTS out of range");
  end
  if (LOSS < 1 || LOSS > 15)
  begin : g_bad_loss
    $error("LOSS out of range");
  end

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction

  logic [POINTS-1:0] last_q [3];
  logic [2:0] present;
  logic [2:0] hit;
  logic [4:0] caddr [3];
  outsel_pkg::src_t src_d;
  logic [POINTS-1:0] points_d;

  assign caddr[0] = outsel_pkg::ADDR_CTRL_A;
  assign caddr[1] = outsel_pkg::ADDR_CTRL_B;
  assign caddr[2] = outsel_pkg::ADDR_CTRL_C;

  // ---------------------------------------------------------------
  // per controller capture and presence
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ctrl
      assign hit[g] = i_cmd_valid && addr_hit(i_cmd_addr, caddr[g]);
      always_ff @(posedge i_clk_sys or posedge i_rst)
      begin
        if (i_rst)
          last_q[g] <= '0;
        else if (hit[g])
          last_q[g] <= i_cmd_data;
      end
      // absence after LOSS quiet scans, in every redundancy mode
      presence_tracker #(.LOSS(LOSS)) presence_tracker_i (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_scan_end(i_scan_end),
        .i_got_data(hit[g]),
        .o_present(present[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // source priority
  // ---------------------------------------------------------------
  always_comb
  begin
    src_d = outsel_pkg::SRC_NONE;
    if (present[0])
      src_d = outsel_pkg::SRC_A;
    else if (present[1])
      src_d = outsel_pkg::SRC_B;
    else if (present[2] && i_three_source)
      src_d = outsel_pkg::SRC_C;
  end

  // ---------------------------------------------------------------
  // point drive per mode
  // ---------------------------------------------------------------
  always_comb
  begin
    points_d = o_points;
    case (outsel_pkg::red_mode_t'(i_red_mode))
      outsel_pkg::MODE_NONE:
      begin
        if (present[0])
          points_d = last_q[0];
        else if (!i_hold_last)
          points_d = i_default_state;
      end
      outsel_pkg::MODE_DUPLEX:
      begin
        if (present[0] && present[1])
          points_d = (last_q[0] & last_q[1]) |
            (i_duplex_default & (last_q[0] ^ last_q[1]));
        else if (present[0])
          points_d = last_q[0];
        else if (present[1])
          points_d = last_q[1];
        else if (!i_hold_last)
          points_d = i_default_state;
      end
      outsel_pkg::MODE_STANDBY:
      begin
        case (src_d)
          outsel_pkg::SRC_A: points_d = last_q[0];
          outsel_pkg::SRC_B: points_d = last_q[1];
          outsel_pkg::SRC_C: points_d = last_q[2];
          default:
          begin
            if (!i_hold_last)
              points_d = i_default_state;
          end
        endcase
      end
      default: points_d = i_voted_data;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_points <= '0;
    else
      o_points <= points_d;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_source <= outsel_pkg::SRC_NONE;
      o_present <= 3'h0;
    end
    else
    begin
      o_source <= src_d;
      o_present <= present;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_a_wins;
    @(posedge i_clk_sys) disable iff (i_rst)
      present[0] |=> (o_source == 4'h1);
  endproperty
  a_a_wins: assert property (p_a_wins) else $error("A not in control");

  property p_duplex_agree;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h1 && present[0] && present[1]) |=>
        ((o_points & ~($past(last_q[0]) ^ $past(last_q[1])))
         == ($past(last_q[0]) & ~($past(last_q[0]) ^ $past(last_q[1]))));
  endproperty
  a_duplex_agree: assert property (p_duplex_agree) else $error("agreed state lost");

  property p_duplex_diff;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h1 && present[0] && present[1]) |=>
        ((o_points & ($past(last_q[0]) ^ $past(last_q[1])))
         == ($past(i_duplex_default) & ($past(last_q[0]) ^ $past(last_q[1]))));
  endproperty
  a_duplex_diff: assert property (p_duplex_diff) else $error("duplex default not used");

  property p_b_fallback;
    @(posedge i_clk_sys) disable iff (i_rst)
      (!present[0] && present[1]) |=> (o_source == 4'h2);
  endproperty
  a_b_fallback: assert property (p_b_fallback) else $error("B not selected");

  property p_c_two_src;
    @(posedge i_clk_sys) disable iff (i_rst)
      !i_three_source |=> (o_source != 4'h4);
  endproperty
  a_c_two_src: assert property (p_c_two_src) else $error("C used in two-source");

  property p_none_default;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h2 && src_d == outsel_pkg::SRC_NONE && !i_hold_last)
        |=> (o_points == $past(i_default_state));
  endproperty
  a_none_default: assert property (p_none_default) else $error("default not driven");

  property p_none_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h2 && src_d == outsel_pkg::SRC_NONE && i_hold_last)
        |=> $stable(o_points);
  endproperty
  a_none_hold: assert property (p_none_hold) else $error("hold not kept");

  property p_simplex;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h0 && present[0]) |=> (o_points == $past(last_q[0]));
  endproperty
  a_simplex: assert property (p_simplex) else $error("simplex drive wrong");

  property p_duplex_single;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_red_mode == 2'h1 && !present[0] && present[1]) |=> (o_points == $past(last_q[1]));
  endproperty
  a_duplex_single: assert property (p_duplex_single) else $error("survivor not used");
endmodule // output_selector

// >>> sim/ctrl_model.sv
// far-side model: three redundant controllers sharing the serial bus
module ctrl_model (
  // clock
  input wire logic i_clk_sys,
  // controller enables and commanded states
  input wire logic [2:0] i_en,
  input wire logic [15:0] i_data_a,
  input wire logic [15:0] i_data_b,
  input wire logic [15:0] i_data_c,
  // bus side
  output logic o_scan_end = 1'b0,
  output logic o_cmd_valid = 1'b0,
  output logic [4:0] o_cmd_addr = 5'h00,
  output logic [15:0] o_cmd_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase = 3'h0;
  logic send_v;
  logic [4:0] addr_v;
  logic [15:0] data_v;
  // ----
  // scan sequencer, eight cycles a scan
  // ----
  always @(negedge i_clk_sys)
  begin
    // idle bus keeps changing so a stale frame is never mistaken
    send_v = 1'b0;
    addr_v = ~o_cmd_addr;
    data_v = ~o_cmd_data;
    // late slots so an enable change after a scan end applies to the next scan
    case (phase)
      3'h3:
      begin
        send_v = i_en[0];
        addr_v = outsel_pkg::ADDR_CTRL_A;
        data_v = i_data_a;
      end
      3'h4:
      begin
        send_v = i_en[1];
        addr_v = outsel_pkg::ADDR_CTRL_B;
        data_v = i_data_b;
      end
      3'h5:
      begin
        send_v = i_en[2];
        addr_v = outsel_pkg::ADDR_CTRL_C;
        data_v = i_data_c;
      end
      default: ;
    endcase
    phase <= phase + 3'h1;
    // one scan pulse shared by every device on the bus
    o_scan_end <= (phase == 3'h6);
    o_cmd_valid <= send_v;
    o_cmd_addr <= addr_v;
    o_cmd_data <= data_v;
  end
endmodule  // ctrl_model

// >>> sim/redundant_output_selector_tb.sv
// self-checking bench for the output source selector
module redundant_output_selector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] DA = 16'hA5C3;
  localparam logic [15:0] DB = 16'h5AC3;
  localparam logic [15:0] DC = 16'h0F0F;
  localparam logic [15:0] DDEF = 16'hF0F0;
  localparam logic [15:0] DEF = 16'h1234;
  localparam logic [15:0] VOTE = 16'hBEEF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  logic three = 1'b0;
  logic hold = 1'b0;
  logic [2:0] en = 3'h0;
  logic scan_end, cmd_valid;
  logic [4:0] cmd_addr;
  logic [15:0] cmd_data, points;
  logic [3:0] source;
  logic [2:0] present;
  int num_errors = 0;
  int compares = 0;
  output_selector #(.POINTS(16), .LOSS(outsel_pkg::LOSS_SCANS)) output_selector_i (
    .i_clk_sys(clk), .i_rst(rst), .i_red_mode(mode), .i_three_source(three),
    .i_hold_last(hold), .i_default_state(DEF), .i_duplex_default(DDEF),
    .i_scan_end(scan_end), .i_cmd_valid(cmd_valid), .i_cmd_addr(cmd_addr),
    .i_cmd_data(cmd_data), .i_voted_data(VOTE), .o_points(points),
    .o_source(source), .o_present(present));
  ctrl_model ctrl_model_i (
    .i_clk_sys(clk), .i_en(en), .i_data_a(DA), .i_data_b(DB), .i_data_c(DC),
    .o_scan_end(scan_end), .o_cmd_valid(cmd_valid), .o_cmd_addr(cmd_addr),
    .o_cmd_data(cmd_data));
  initial
    forever #25 clk = ~clk;
  // ----
  // shared tasks
  // ----
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chk_src(input logic [3:0] exp);
    chk({12'h000, source}, {12'h000, exp});
  endtask
  // returns three cycles after the n-th scan end, so loss has reached the ports
  task scans(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (scan_end !== 1'b1)
        @(posedge clk);
    end
    repeat (3)
      @(negedge clk);
  endtask
  task start(input logic [1:0] m, input logic t, input logic h, input logic [2:0] e);
    @(negedge clk);
    rst = 1'b1;
    mode = m;
    three = t;
    hold = h;
    en <= e;
    repeat (4)
      @(negedge clk);
    rst = 1'b0;
  endtask
  // ----
  // scenarios
  // ----
  task t_none;
    start(2'h0, 1'b0, 1'b0, 3'h1);
    scans(2);
    chk(points, DA);
    chk_src(4'h1);
    en <= 3'h0;
    scans(3);
    chk(points, DEF);
    $display("test none done");
  endtask
  task t_duplex;
    start(2'h1, 1'b0, 1'b0, 3'h3);
    scans(2);
    // low byte agreed, high byte differs and takes the duplex default
    chk(points, {DDEF[15:8], DA[7:0]});
    en <= 3'h2;
    scans(4);
    chk(points, DB);
    chk({13'h0, present}, 16'h0002);
    en <= 3'h1;
    scans(4);
    chk(points, DA);
    chk({13'h0, present}, 16'h0001);
    $display("test duplex done");
  endtask
  task t_standby2;
    start(2'h2, 1'b0, 1'b0, 3'h3);
    scans(2);
    chk(points, DA);
    en <= 3'h2;
    scans(2);
    chk_src(4'h1);
    scans(1);
    chk_src(4'h2);
    chk(points, DB);
    en <= 3'h0;
    scans(3);
    chk(points, DEF);
    en <= 3'h3;
    scans(1);
    chk_src(4'h1);
    $display("test two-source standby done");
  endtask
  task t_standby3;
    start(2'h2, 1'b1, 1'b1, 3'h4);
    scans(2);
    chk(points, DC);
    en <= 3'h6;
    scans(1);
    chk(points, DB);
    chk({13'h0, present}, 16'h0006);
    en <= 3'h0;
    scans(2);
    chk_src(4'h2);
    scans(1);
    chk_src(4'h8);
    chk(points, DB);
    $display("test three-source standby done");
  endtask
  task t_voted;
    start(2'h3, 1'b0, 1'b0, 3'h7);
    scans(1);
    chk(points, VOTE);
    $display("test voted done");
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // about 250 cycles of tests, so this limit is never reached by a live design
  initial
  begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial
  begin
    t_none;
    t_duplex;
    t_standby2;
    t_standby3;
    t_voted;
    complete_run;
  end
endmodule  // redundant_output_selector_tb
